// [rx_beat_fifo.sv]
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/100ps
module rx_beat_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);

    localparam int PTR_W = $clog2(DEPTH);

    // ****************************************
    // Storage and pointers
    // ****************************************
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PTR_W-1:0] wr_ptr_q;
    logic [PTR_W-1:0] rd_ptr_q;
    logic [PTR_W:0] count_q;

    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = (count_q != (PTR_W+1)'(DEPTH));
    assign out_valid_out = (count_q != '0);
    assign out_data_out = mem_q[rd_ptr_q];

    function automatic logic [PTR_W-1:0] next_ptr(input logic [PTR_W-1:0] p);
        next_ptr = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    always_ff @(posedge clk_sys_in) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_in;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= next_ptr(wr_ptr_q);
            end
            if (pop) begin
                rd_ptr_q <= next_ptr(rd_ptr_q);
            end
            count_q <= count_q + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
        end
    end

endmodule

// [rx_packet_passthrough_port.sv]
// Receive pass-through port: routes unconsumed packets to user logic
//
// Functional notes
// - With destination checking on, packets with a foreign destination or unsupported ftype go to the user port.
// - With destination checking off, only request packets with an unsupported ftype go to the user port.
// - In maintenance-only mode every non-maintenance request packet goes to the user port; responses go there only with destination checking on.
// - The first beat of a diverted packet shows valid and start-of-packet together.
// - The size output is valid on the start beat and gives the number of beats in the packet.
// - Word one carries tt in [53:52]; tt 0 means 8-bit IDs with destination in [47:40].
// - Word one carries ftype in [51:48]; value 5 marks a write-class packet.
// - With 8-bit IDs, ttype sits in [31:28] of word one; value 4 is an NWRITE.
// - Write size sits in [27:24] of word one and the word pointer in bit 50 of word two.
// - The 29-bit address is split into [15:0] of word one and [63:51] of word two.
// - The end beat shows the count of unused trailing bytes on the empty output.
// - Short packets keep their embedded CRC field in the forwarded stream.
// - With 16-bit IDs the ID fields widen and later fields shift right into later beats.
`timescale 1ns/100ps
module rx_packet_passthrough_port (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Configuration
    input wire logic dest_check_en_in,
    input wire logic [rx_passthrough_pkg::ID_W-1:0] base_id_in,
    input wire logic maint_only_in,
    input wire logic [15:0] ftype_supported_in,
    // Packets from the transport layer
    input wire logic tl_valid_in,
    output logic tl_ready_out,
    input wire logic [rx_passthrough_pkg::DATA_W-1:0] tl_data_in,
    input wire logic tl_sop_in,
    input wire logic tl_eop_in,
    input wire logic [rx_passthrough_pkg::EMPTY_W-1:0] tl_empty_in,
    input wire logic [rx_passthrough_pkg::SIZE_W-1:0] tl_size_in,
    // Consumed packets to the core's own functions
    output logic core_valid_out,
    input wire logic core_ready_in,
    output rx_passthrough_pkg::beat_type core_beat_out,
    // Pass-through port to user logic
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    output logic [rx_passthrough_pkg::DATA_W-1:0] rx_data_out,
    output logic rx_sop_out,
    output logic rx_eop_out,
    output logic [rx_passthrough_pkg::EMPTY_W-1:0] rx_empty_out,
    output logic [rx_passthrough_pkg::SIZE_W-1:0] rx_size_out,
    output rx_passthrough_pkg::header_type rx_header_out,
    output logic rx_nwrite_out
);

    // ****************************************
    // Header decode
    // ****************************************
    function automatic rx_passthrough_pkg::header_type decode_header(
        input logic [rx_passthrough_pkg::DATA_W-1:0] w
    );
        rx_passthrough_pkg::header_type h;
        h = '0;
        h.tt = w[rx_passthrough_pkg::TT_LSB +: 2];
        h.ftype = w[rx_passthrough_pkg::FTYPE_LSB +: 4];
        if (h.tt == rx_passthrough_pkg::TT_ID16) begin
            h.dest_id = w[rx_passthrough_pkg::DEST16_LSB +: 16];
            h.ttype = 4'h0;
            h.wrsize = 4'h0;
        end else begin
            h.dest_id = {8'h00, w[rx_passthrough_pkg::DEST8_LSB +: 8]};
            h.ttype = w[rx_passthrough_pkg::TTYPE8_LSB +: 4];
            h.wrsize = w[rx_passthrough_pkg::WRSIZE8_LSB +: 4];
        end
        decode_header = h;
    endfunction

    function automatic logic ftype_ok(
        input logic [3:0] ftype,
        input logic maint_only,
        input logic [15:0] mask
    );
        ftype_ok = maint_only ? (ftype == rx_passthrough_pkg::FTYPE_MAINT) : mask[ftype];
    endfunction

    // ****************************************
    // Routing decision on the start beat
    // ****************************************
    rx_passthrough_pkg::header_type tl_hdr;
    wire tl_supported;
    wire tl_foreign;
    wire dest_diff8;
    wire dest_diff16;
    wire tl_request;
    wire divert_now;

    assign tl_hdr = decode_header(tl_data_in);
    assign tl_supported = ftype_ok(tl_hdr.ftype, maint_only_in, ftype_supported_in);
    assign dest_diff8 = (tl_hdr.dest_id[7:0] != base_id_in[7:0]);
    assign dest_diff16 = (tl_hdr.dest_id != base_id_in);
    assign tl_foreign = (tl_hdr.tt == rx_passthrough_pkg::TT_ID16) ?
        dest_diff16 : dest_diff8;
    assign tl_request = (tl_hdr.ftype != rx_passthrough_pkg::FTYPE_RESPONSE);
    assign divert_now = dest_check_en_in ? (tl_foreign || !tl_supported) :
        (tl_request && !tl_supported);

    // ****************************************
    // Route state held from start beat to end beat
    // ****************************************
    typedef enum logic [1:0] {
        ROUTE_IDLE,
        ROUTE_CORE,
        ROUTE_USER
    } route_type;

    route_type route_q;
    route_type route_d;
    route_type route_pick;
    wire divert_sel = tl_sop_in ? divert_now : (route_q == ROUTE_USER);
    assign route_pick = divert_sel ? ROUTE_USER : ROUTE_CORE;

    // ****************************************
    // Beat formation and handshakes
    // ****************************************
    rx_passthrough_pkg::beat_type tl_beat;
    rx_passthrough_pkg::beat_type fifo_out;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire core_slot_ready = !core_valid_out || core_ready_in;
    wire tl_accept = tl_valid_in && tl_ready_out;
    wire fifo_push = tl_valid_in && divert_sel;

    // Stream forwarded untouched, so layout, payload order and short-packet CRC stay in place
    assign tl_beat.data = tl_data_in;
    assign tl_beat.sop = tl_sop_in;
    assign tl_beat.eop = tl_eop_in;
    assign tl_beat.empty = tl_empty_in;
    assign tl_beat.size = tl_size_in;

    // ****************************************
    // Transport ready
    // ****************************************
    assign tl_ready_out = divert_sel ? fifo_in_ready : core_slot_ready;

    // ****************************************
    // Route state update
    // ****************************************
    always_comb begin
        route_d = route_q;
        unique case (route_q)
            ROUTE_IDLE: begin
                if (tl_accept && !tl_eop_in) begin
                    route_d = route_pick;
                end
            end
            ROUTE_CORE, ROUTE_USER: begin
                if (tl_accept && tl_eop_in) begin
                    route_d = ROUTE_IDLE;
                end else if (tl_accept && tl_sop_in) begin
                    route_d = route_pick;
                end
            end
            default: begin
                route_d = ROUTE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            route_q <= route_type'(rx_passthrough_pkg::ROUTE_RESET);
        end else begin
            route_q <= route_d;
        end
    end

    // ****************************************
    // Core path register
    // ****************************************
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            core_valid_out <= 1'b0;
            core_beat_out <= '0;
        end else if (core_slot_ready) begin
            core_valid_out <= tl_valid_in && !divert_sel;
            core_beat_out <= tl_beat;
        end
    end

    // ****************************************
    // Pass-through buffer
    // ****************************************
    rx_beat_fifo #(
        .WIDTH($bits(rx_passthrough_pkg::beat_type)),
        .DEPTH(rx_passthrough_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys_in(clk_sys_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(fifo_push),
        .in_ready_out(fifo_in_ready),
        .in_data_in(tl_beat),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(rx_ready_in),
        .out_data_out(fifo_out)
    );

    // ****************************************
    // User port outputs
    // ****************************************
    // Head entry is held until popped on valid and ready
    assign rx_valid_out = fifo_out_valid;
    assign rx_data_out = fifo_out.data;
    assign rx_sop_out = fifo_out.sop;
    assign rx_eop_out = fifo_out.eop;
    assign rx_empty_out = fifo_out.eop ? fifo_out.empty : '0;
    assign rx_size_out = fifo_out.sop ? fifo_out.size : '0;

    // ****************************************
    // Start-beat header decode
    // ****************************************
    wire hdr_id8;
    wire hdr_write;
    wire hdr_nwrite;

    assign rx_header_out = fifo_out.sop ? decode_header(fifo_out.data) : '0;
    assign hdr_id8 = (rx_header_out.tt == rx_passthrough_pkg::TT_ID8);
    assign hdr_write = (rx_header_out.ftype == rx_passthrough_pkg::FTYPE_WRITE);
    assign hdr_nwrite = (rx_header_out.ttype == rx_passthrough_pkg::TTYPE_NWRITE);
    assign rx_nwrite_out = fifo_out.sop && hdr_id8 && hdr_write && hdr_nwrite;

endmodule

// [rx_packet_passthrough_port_sva.sv]
// Assertions on the pass-through port outputs
`timescale 1ns/100ps
module rx_pt_checker (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // User port
    input wire logic rx_valid_out,
    input wire logic rx_ready_in,
    input wire logic [63:0] rx_data_out,
    input wire logic rx_sop_out,
    input wire logic rx_eop_out,
    input wire logic [2:0] rx_empty_out,
    input wire logic [7:0] rx_size_out,
    input wire rx_passthrough_pkg::header_type rx_header_out,
    input wire logic rx_nwrite_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);
    // Inside a packet once a non-final beat is taken
    logic in_pkt_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            in_pkt_q <= 1'b0;
        end else if (rx_valid_out && rx_ready_in) begin
            in_pkt_q <= !rx_eop_out;
        end
    end
    sequence s_head16;
        rx_valid_out && rx_sop_out && rx_data_out[53:52] == 2'h1;
    endsequence
    sequence s_head;
        rx_valid_out && rx_sop_out;
    endsequence
    sequence s_head8;
        rx_valid_out && rx_sop_out && rx_data_out[53:52] == 2'h0;
    endsequence
    sequence s_stall;
        rx_valid_out && !rx_ready_in;
    endsequence
    property p_hold;
        s_stall |=> rx_valid_out && $stable(rx_data_out) && $stable(rx_eop_out);
    endproperty
    property p_tt;
        s_head |-> rx_header_out.tt == rx_data_out[53:52];
    endproperty
    property p_dest;
        s_head8 |-> rx_header_out.dest_id[7:0] == rx_data_out[47:40];
    endproperty
    property p_ftype;
        s_head |-> rx_header_out.ftype == rx_data_out[51:48];
    endproperty
    property p_ttype;
        s_head8 |-> rx_header_out.ttype == rx_data_out[31:28]
            && rx_header_out.wrsize == rx_data_out[27:24];
    endproperty
    property p_nwrite;
        s_head |-> rx_nwrite_out == (rx_data_out[53:48] == 6'h05
            && rx_data_out[31:28] == 4'h4);
    endproperty
    property p_size;
        rx_valid_out |-> (rx_size_out != 8'h00) == rx_sop_out;
    endproperty
    property p_empty;
        rx_valid_out && !rx_eop_out |-> rx_empty_out == 3'h0;
    endproperty
    property p_dest16;
        s_head16 |-> rx_header_out.dest_id == rx_data_out[47:32];
    endproperty
    property p_first;
        rx_valid_out && !in_pkt_q |-> rx_sop_out;
    endproperty
    a_hold: assert property (p_hold) else $error("beat changed while stalled");
    a_tt: assert property (p_tt) else $error("tt decode wrong");
    a_dest: assert property (p_dest) else $error("dest decode wrong");
    a_ftype: assert property (p_ftype) else $error("ftype decode wrong");
    a_ttype: assert property (p_ttype) else $error("ttype decode wrong");
    a_nwrite: assert property (p_nwrite) else $error("nwrite flag wrong");
    a_size: assert property (p_size) else $error("size off start beat");
    a_empty: assert property (p_empty) else $error("empty off end beat");
    a_dest16: assert property (p_dest16) else $error("wide dest decode wrong");
    a_first: assert property (p_first) else $error("first beat without start");
endmodule
bind rx_packet_passthrough_port rx_pt_checker u_rx_pt_checker (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .rx_valid_out(rx_valid_out),
    .rx_ready_in(rx_ready_in), .rx_data_out(rx_data_out), .rx_sop_out(rx_sop_out),
    .rx_eop_out(rx_eop_out), .rx_empty_out(rx_empty_out), .rx_size_out(rx_size_out),
    .rx_header_out(rx_header_out), .rx_nwrite_out(rx_nwrite_out));

// [rx_passthrough_pkg.sv]
// Shared constants and types for the receive pass-through port
package rx_passthrough_pkg;

    // ****************************************
    // Beat and field widths, and buffer depth
    // ****************************************
    localparam int DATA_W = 64;
    localparam int EMPTY_W = 3;
    localparam int SIZE_W = 8;
    localparam int ID_W = 16;
    localparam int FIFO_DEPTH = 8;

    // ****************************************
    // First-word header field positions
    // ****************************************
    localparam int TT_LSB = 52;
    localparam int FTYPE_LSB = 48;
    localparam int DEST8_LSB = 40;
    localparam int DEST16_LSB = 32;
    localparam int TTYPE8_LSB = 28;
    localparam int WRSIZE8_LSB = 24;
    localparam int ADDR_HI8_LSB = 0;

    // ****************************************
    // Second-word field positions
    // ****************************************
    localparam int ADDR_LO8_LSB = 51;
    localparam int WDPTR8_BIT = 50;
    localparam int PAYLOAD8_MSB = 47;

    // ****************************************
    // Field codes
    // ****************************************
    localparam logic [1:0] TT_ID8 = 2'h0;
    localparam logic [1:0] TT_ID16 = 2'h1;
    localparam logic [3:0] FTYPE_WRITE = 4'h5;
    localparam logic [3:0] FTYPE_MAINT = 4'h8;
    localparam logic [3:0] FTYPE_RESPONSE = 4'hd;
    localparam logic [3:0] TTYPE_NWRITE = 4'h4;

    // ****************************************
    // Intermediate CRC threshold in bytes
    // ****************************************
    localparam int CRC_KEEP_BYTES = 80;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [1:0] ROUTE_RESET = 2'h0;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic sop;
        logic eop;
        logic [EMPTY_W-1:0] empty;
        logic [SIZE_W-1:0] size;
    } beat_type;

    typedef struct packed {
        logic [1:0] tt;
        logic [3:0] ftype;
        logic [ID_W-1:0] dest_id;
        logic [3:0] ttype;
        logic [3:0] wrsize;
    } header_type;

endpackage

// [rx_user_sink.sv]
// Behavioural user logic sink
`timescale 1ns/100ps
module rx_user_sink (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // Mode
    input wire logic hold_in,
    input wire logic slow_in,
    // Handshake
    output logic ready_out
);
    logic [1:0] tick_q;
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            tick_q <= 2'h0;
            ready_out <= 1'b0;
        end else begin
            tick_q <= tick_q + 2'h1;
            ready_out <= !hold_in && (!slow_in || tick_q == 2'h3);
        end
    end
endmodule

// [tb_rx_packet_passthrough_port.sv]
// Testbench for the receive pass-through port
`timescale 1ns/100ps
module tb_rx_packet_passthrough_port;
    logic clk_sys_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic dest_check_en_in = 1'b1;
    logic maint_only_in = 1'b0;
    logic tl_valid_in = 1'b0;
    logic core_ready_in = 1'b1;
    logic hold = 1'b0;
    logic slow = 1'b0;
    logic id16 = 1'b0;
    logic [7:0] dst_hi = 8'h00;
    logic tl_ready_out, core_valid_out, rx_valid_out, rx_ready_in;
    logic rx_sop_out, rx_eop_out, rx_nwrite_out;
    logic [63:0] rx_data_out;
    logic [2:0] rx_empty_out;
    logic [7:0] rx_size_out;
    rx_passthrough_pkg::beat_type tl_q = '0;
    rx_passthrough_pkg::beat_type core_beat_out;
    rx_passthrough_pkg::header_type rx_header_out;
    rx_passthrough_pkg::beat_type rxq[$];
    rx_passthrough_pkg::beat_type coreq[$];
    int error_cnt = 0;
    int n_checks = 0;

    always #25 clk_sys_in = ~clk_sys_in;

    rx_packet_passthrough_port u_rx_packet_passthrough_port (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .dest_check_en_in(dest_check_en_in),
        .base_id_in(16'h0033), .maint_only_in(maint_only_in), .ftype_supported_in(16'h0020),
        .tl_valid_in(tl_valid_in), .tl_ready_out(tl_ready_out), .tl_data_in(tl_q.data),
        .tl_sop_in(tl_q.sop), .tl_eop_in(tl_q.eop), .tl_empty_in(tl_q.empty),
        .tl_size_in(tl_q.size), .core_valid_out(core_valid_out), .core_ready_in(core_ready_in),
        .core_beat_out(core_beat_out), .rx_valid_out(rx_valid_out), .rx_ready_in(rx_ready_in),
        .rx_data_out(rx_data_out), .rx_sop_out(rx_sop_out), .rx_eop_out(rx_eop_out),
        .rx_empty_out(rx_empty_out), .rx_size_out(rx_size_out),
        .rx_header_out(rx_header_out), .rx_nwrite_out(rx_nwrite_out));

    rx_user_sink u_rx_user_sink (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .hold_in(hold), .slow_in(slow), .ready_out(rx_ready_in));

    always @(posedge clk_sys_in) begin
        if (rx_valid_out && rx_ready_in)
            rxq.push_back(rx_passthrough_pkg::beat_type'({rx_data_out, rx_sop_out,
                rx_eop_out, rx_empty_out, rx_size_out}));
        if (core_valid_out && core_ready_in)
            coreq.push_back(core_beat_out);
    end

    task automatic chk_beat(input rx_passthrough_pkg::beat_type got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t beat %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, exp);
        n_checks++;
        if (got != exp) begin
            error_cnt++;
            $display("[FAIL] %0t count %0d expected %0d", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        $display("Checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic send(input rx_passthrough_pkg::beat_type b);
        tl_valid_in <= 1'b1;
        tl_q <= b;
        @(negedge clk_sys_in);
        while (!tl_ready_out) @(negedge clk_sys_in);
        @(posedge clk_sys_in);
    endtask

    // Sends one packet and checks it arrives whole on the expected side
    task automatic run_pkt(input logic [3:0] ft, input logic [7:0] dst, input int n, input bit to_rx);
        rx_passthrough_pkg::beat_type eq[$];
        rx_passthrough_pkg::beat_type b;
        int k;
        rxq.delete();
        coreq.delete();
        for (int i = 0; i < n; i++) begin
            b.data = {48'h0001_0203_0405, 16'(i)};
            if (i == 0)
                b.data = {10'h000, 2'h0, ft, dst, 8'hcc, 8'h4c, 8'h00, 16'h5a5a};
            if (i == 0 && id16)
                b.data = {10'h000, 2'h1, ft, dst_hi, dst, 16'hccdc, 16'h4c00};
            b.sop = (i == 0);
            b.eop = (i == n - 1);
            b.empty = b.eop ? 3'h4 : 3'h0;
            b.size = b.sop ? 8'(n) : 8'h00;
            eq.push_back(b);
            send(b);
        end
        tl_valid_in <= 1'b0;
        k = 0;
        while (rxq.size() + coreq.size() < n && k < 300) begin
            @(posedge clk_sys_in);
            k++;
        end
        chk_cnt(rxq.size() + coreq.size(), n);
        chk_cnt(to_rx ? rxq.size() : coreq.size(), n);
        for (int i = 0; i < n; i++)
            chk_beat(to_rx ? rxq[i] : coreq[i], eq[i]);
    endtask

    task automatic t_dest;
        slow <= 1'b1;
        run_pkt(4'h5, 8'haa, 5, 1'b1);
        slow <= 1'b0;
        run_pkt(4'h5, 8'h33, 3, 1'b0);
        run_pkt(4'h6, 8'h33, 3, 1'b1);
    endtask

    task automatic t_nocheck;
        dest_check_en_in <= 1'b0;
        run_pkt(4'h5, 8'haa, 3, 1'b0);
        run_pkt(4'h6, 8'haa, 2, 1'b1);
        run_pkt(4'hd, 8'haa, 2, 1'b0);
        dest_check_en_in <= 1'b1;
    endtask

    task automatic t_maint;
        maint_only_in <= 1'b1;
        run_pkt(4'h8, 8'h33, 2, 1'b0);
        run_pkt(4'h5, 8'h33, 2, 1'b1);
        maint_only_in <= 1'b0;
    endtask

    // Wide IDs: high byte alone must make the packet foreign
    task automatic t_id16;
        id16 = 1'b1;
        dst_hi = 8'h12;
        run_pkt(4'h5, 8'h33, 2, 1'b1);
        dst_hi = 8'h00;
        run_pkt(4'h5, 8'h33, 2, 1'b0);
        id16 = 1'b0;
    endtask

    task automatic t_fill;
        hold <= 1'b1;
        fork
            run_pkt(4'h5, 8'haa, 12, 1'b1);
            begin
                repeat (40) @(posedge clk_sys_in);
                chk_bit(tl_ready_out, 1'b0);
                hold <= 1'b0;
            end
        join
    endtask

    initial begin
        repeat (8) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        @(posedge clk_sys_in);
        t_dest();
        t_nocheck();
        t_maint();
        t_id16();
        t_fill();
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        error_cnt++;
        end_of_test();
    end
endmodule
